// ---- dac_pkg.sv ----
package dac_pkg;

    localparam int unsigned CLK_MHZ       = 125;
    localparam int unsigned OFS_W         = 6;
    localparam logic [5:0]  OFS_CSR_LAST  = 6'h0E;
    localparam logic [5:0]  OFS_MEM_FIRST = 6'h10;
    localparam logic [5:0]  OFS_MEM_LAST  = 6'h2E;
    localparam int unsigned CODE_W        = 12;
    localparam int unsigned NCHAN         = 8;
    localparam int unsigned NWORD         = 16;

    localparam int unsigned BIT_LAMP      = 11;
    localparam int unsigned BIT_SIGNED    = 10;
    localparam int unsigned BIT_VDRV      = 9;
    localparam int unsigned BIT_IDRV      = 8;
    localparam int unsigned BIT_SCAN      = 7;
    localparam logic [3:0]  STAT_FIXED_HI = 4'hF;
    localparam logic [3:0]  STAT_FIXED_LO = 4'h0;

    localparam int unsigned RESP_US       = 792;
    localparam int unsigned RESP_CYC      = RESP_US * CLK_MHZ;
    // Dwell per channel so a full sweep of eight fits the response time
    localparam int unsigned DWELL_CYC     = RESP_CYC / NCHAN;

    localparam logic [11:0] CODE_MIN      = 12'h000;
    localparam logic [11:0] SIGN_FLIP     = 12'h800;

    typedef struct packed {
        logic lamp_off;
        logic signed_sel;
        logic vdrv_on;
        logic idrv_on;
        logic scan_on;
    } dac_ctrl_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  ofs;
        logic [1:0]  be;
        logic [15:0] wdata;
    } dac_req_t;

    typedef struct packed {
        logic [2:0]  chan;
        logic [11:0] code;
        logic        strobe;
        logic        v_connect;
        logic        i_enable;
        logic        i_force_min;
        logic        fail_lamp_on;
    } dac_conv_t;

endpackage

// ---- dac_ctrl.sv ----
`timescale 1ns/1ps

// Contract
// - Sixteen-bit status word, byte or word readable, every bit defined.
// - Status bits 15..12 always read one.
// - Status bits 11..8 echo lamp, signed, voltage and current control bits.
// - Status bit 7 echoes the scan enable control bit.
// - Status bits 6..3 always read zero.
// - Status bits 2..0 show the live refresh channel counter.
// - Reset clears all control bits: lamp lit, outputs off, scan stopped.
// - Eight channel codes as consecutive words, writable and readable back.
// - Codes held in bits 11..0; upper four bits dropped, read zero.
// - With scan on, a written code reaches its output within 792 us.
// - Binary mode passes the code unsigned: 000 minimum, FFF maximum.
// - Signed mode: 7FF maximum, 800 minimum, zero mid-scale.
// - Voltage enable high connects voltage channels; low leaves them open.
// - Current channels follow codes only with voltage and current enable high.
// - Voltage high, current low: current channels forced to range minimum.
// - Refresh cycles run only while scan enable is high.
// - Writes to 00..0E load control; reads there return the status.
// - Offsets 10..2E are sixteen storage words; 30..3F reserved.
module dac_ctrl #(
    parameter int unsigned DWELL = dac_pkg::DWELL_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire dac_pkg::dac_req_t req,
    output logic [15:0]            rdata,
    output logic                   rvalid,
    output dac_pkg::dac_conv_t     conv
);

    typedef struct packed {
        dac_pkg::dac_ctrl_t ctrl;
        logic [2:0]         chan;
        logic [31:0]        dwell;
        logic [15:0]        rdata;
        logic               rvalid;
        dac_pkg::dac_conv_t conv;
    } dac_state_t;

    dac_state_t s_q;
    dac_state_t s_d;
    // Code storage kept apart: it has no reset, like the SRAM it stands for
    logic [11:0] mem_q [dac_pkg::NWORD];
    logic [3:0]  widx;
    logic        csr_hit;
    logic        mem_hit;
    logic [15:0] status;
    logic [11:0] cur_code;

    always_comb
    begin
        csr_hit = req.ofs <= dac_pkg::OFS_CSR_LAST;
        mem_hit = req.ofs >= dac_pkg::OFS_MEM_FIRST
               && req.ofs <= dac_pkg::OFS_MEM_LAST;
        widx    = 4'(req.ofs[4:1] - 4'h8);
        status  = {dac_pkg::STAT_FIXED_HI,
                   s_q.ctrl.lamp_off, s_q.ctrl.signed_sel,
                   s_q.ctrl.vdrv_on, s_q.ctrl.idrv_on,
                   s_q.ctrl.scan_on,
                   dac_pkg::STAT_FIXED_LO,
                   s_q.chan};
        cur_code = mem_q[{1'b0, s_q.chan}];
    end

    // Storage writes, byte lanes honoured; upper nibble never kept
    always_ff @(posedge core_clk)
    begin
        if (req.wr && mem_hit)
        begin
            if (req.be[0])
                mem_q[widx][7:0] <= req.wdata[7:0];
            if (req.be[1])
                mem_q[widx][11:8] <= req.wdata[11:8];
        end
    end

    always_comb
    begin
        s_d = s_q;
        s_d.rvalid = req.rd;
        if (req.rd)
        begin
            if (csr_hit)
                s_d.rdata = status;
            else if (mem_hit)
                s_d.rdata = {4'h0, mem_q[widx]};
            else
                s_d.rdata = 16'h0000;
        end
        // Byte writes update only the lane given
        if (req.wr && csr_hit)
        begin
            if (req.be[1])
            begin
                s_d.ctrl.lamp_off   = req.wdata[dac_pkg::BIT_LAMP];
                s_d.ctrl.signed_sel = req.wdata[dac_pkg::BIT_SIGNED];
                s_d.ctrl.vdrv_on    = req.wdata[dac_pkg::BIT_VDRV];
                s_d.ctrl.idrv_on    = req.wdata[dac_pkg::BIT_IDRV];
            end
            if (req.be[0])
                s_d.ctrl.scan_on = req.wdata[dac_pkg::BIT_SCAN];
        end
        s_d.conv.strobe = 1'b0;
        if (s_q.ctrl.scan_on)
        begin
            if (s_q.dwell == DWELL - 1)
            begin
                s_d.dwell = 32'h0;
                s_d.chan  = 3'(s_q.chan + 3'h1);
                // Refresh one channel per dwell; a full sweep bounds delay
                s_d.conv.strobe = 1'b1;
                s_d.conv.chan   = s_q.chan;
                s_d.conv.code   = s_q.ctrl.signed_sel
                                ? (cur_code ^ dac_pkg::SIGN_FLIP)
                                : cur_code;
            end
            else
                s_d.dwell = s_q.dwell + 32'h1;
        end
        s_d.conv.v_connect   = s_q.ctrl.vdrv_on;
        s_d.conv.i_enable    = s_q.ctrl.vdrv_on && s_q.ctrl.idrv_on;
        s_d.conv.i_force_min = s_q.ctrl.vdrv_on && !s_q.ctrl.idrv_on;
        s_d.conv.fail_lamp_on = !s_q.ctrl.lamp_off;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.conv.fail_lamp_on <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign rdata  = s_q.rdata;
    assign rvalid = s_q.rvalid;
    assign conv   = s_q.conv;

endmodule

// ---- dac_ctrl_properties.sv ----
`timescale 1ns/1ps
module dac_ctrl_properties #(parameter int unsigned DWELL = 4) (
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire dac_pkg::dac_req_t  req,
    input wire logic [15:0]        rdata,
    input wire logic               rvalid,
    input wire dac_pkg::dac_conv_t conv
);
    logic [8:0] gap_q;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            gap_q <= 9'h000;
        else if (conv.strobe)
            gap_q <= 9'h100;
        else if (gap_q[7:0] != 8'hFF)
            gap_q <= gap_q + 9'h001;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence sts_rd;
        req.rd && req.ofs < 6'h10;
    endsequence
    read_answer_a: assert property (1'h1 |=> rvalid == $past(req.rd))
        else $error("read answer timing");
    fixed_high_a: assert property (sts_rd |=> rdata[15:12] == 4'hF)
        else $error("status top bits");
    fixed_low_a: assert property (sts_rd |=> rdata[6:3] == 4'h0)
        else $error("status low fixed bits");
    status_echo_a: assert property (sts_rd |=>
        rdata[11] != conv.fail_lamp_on && rdata[9] == conv.v_connect
        && (rdata[9] & rdata[8]) == conv.i_enable)
        else $error("status echo");
    reserved_zero_a: assert property (req.rd && req.ofs >= 6'h30
        |=> rdata == 16'h0000) else $error("reserved read");
    drive_combo_a: assert property (
        (conv.i_enable ^ conv.i_force_min) == conv.v_connect)
        else $error("output enables");
    chan_step_a: assert property (conv.strobe && gap_q[8]
        |-> conv.chan == $past(conv.chan) + 3'h1) else $error("channel step");
    dwell_gap_a: assert property (conv.strobe
        |-> gap_q[7:0] >= 8'(DWELL - 1)) else $error("strobe spacing");
endmodule

// ---- dac_host.sv ----
`timescale 1ns/1ps
// Host loads codes before enables and scan
module dac_host (
    input  wire logic         core_clk,
    input  wire logic [15:0]  rdata,
    output dac_pkg::dac_req_t req
);
    initial req = '0;
    task automatic put(input logic [5:0] o, input logic [1:0] b,
        input logic [15:0] d);
        @(negedge core_clk);
        req = '{1'h1, 1'h0, o, b, d};
        @(negedge core_clk);
        req.wr = 1'h0;
    endtask
    task automatic get(input logic [5:0] o, output logic [15:0] d);
        @(negedge core_clk);
        req = '{1'h0, 1'h1, o, 2'h3, 16'h0000};
        @(negedge core_clk);
        req.rd = 1'h0;
        d = rdata;
    endtask
endmodule

// ---- test_dac_refresh_control_status.sv ----
`timescale 1ns/1ps
module test_dac_refresh_control_status;
    logic               core_clk = 1'h0;
    logic               rst_n = 1'h0;
    dac_pkg::dac_req_t  req;
    logic [15:0]        rdata;
    logic               rvalid;
    dac_pkg::dac_conv_t conv;
    logic [15:0]        d;
    int                 failures = 0;
    int                 samples_checked = 0;
    int                 cyc = 0;
    logic [11:0] codes [8] = '{12'h000, 12'hFFF, 12'h7FF, 12'h800,
        12'h001, 12'hABC, 12'h555, 12'h123};
    always #4 core_clk = ~core_clk;
    dac_ctrl #(.DWELL(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .req(req), .rdata(rdata), .rvalid(rvalid), .conv(conv));
    dac_host host (.core_clk(core_clk), .rdata(rdata), .req(req));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // First sweep after a change may race it, so only the second counts
    task automatic see(input int c, input logic s);
        int n;
        n = 0;
        while (!(conv.strobe === 1'h1 && conv.chan === 3'(c)) && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        if (c > 7)
            chk(16'(conv.code), {4'h0, codes[c % 8] ^ {s, 11'h000}});
        @(negedge core_clk);
    endtask
    always @(posedge core_clk)
        if (++cyc > 5000)
        begin
            failures++;
            end_sim();
        end
    initial
    begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'h1;
        chk(16'({conv.fail_lamp_on, conv.v_connect}), 16'h0002);
        host.get(6'h0E, d);
        chk(d, 16'hF000);
        for (int i = 0; i < 16; i++)
            host.put(6'(16 + 2 * i), 2'h3, {4'hF, codes[i % 8] ^ 12'(i / 8)});
        for (int i = 0; i < 16; i++)
        begin
            host.get(6'(16 + 2 * i), d);
            chk(d, {4'h0, codes[i % 8] ^ 12'(i / 8)});
        end
        host.put(6'h30, 2'h3, 16'hFFFF);
        host.get(6'h30, d);
        chk(d, 16'h0000);
        for (int k = 0; k < 16; k++)
        begin
            host.put(6'(2 * (k % 8)), 2'h3, 16'(k) << 8);
            host.get(6'(14 - 2 * (k % 8)), d);
            chk(d, 16'hF000 | 16'(k) << 8);
            chk(16'({conv.fail_lamp_on, conv.i_enable, conv.i_force_min}),
                16'({~k[3], k[1] & k[0], k[1] & ~k[0]}));
        end
        host.put(6'h00, 2'h1, 16'hFF80);
        host.get(6'h00, d);
        chk(d & 16'hFFF8, 16'hFF80);
        for (int i = 0; i < 16; i++)
            see(i, 1'h1);
        host.put(6'h00, 2'h2, 16'h0300);
        codes[5] = 12'hFFF;
        host.put(6'h1A, 2'h3, {4'h0, codes[5]});
        for (int i = 0; i < 16; i++)
            see(i, 1'h0);
        host.put(6'h00, 2'h1, 16'h0000);
        repeat (12)
        begin
            @(negedge core_clk);
            chk(16'(conv.strobe), 16'h0000);
        end
        end_sim();
    end
endmodule
bind dac_ctrl dac_ctrl_properties #(.DWELL(DWELL)) chk_i (.core_clk(core_clk),
    .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid), .conv(conv));
